// File: common/erxf_pkg.sv
/*
  erxf_pkg: register map, field positions, reset values and mode codes
  of the receive filter, interrupt flag and dropped-frame logic.
  Assumes one 32-bit register bus with word-aligned registers.
*/
package erxf_pkg;

  // ==========================================================
  // register map (register indices and byte offsets within the block)
  localparam logic [3:0] REG_FILTER_IDX = 4'h0; // rx_filter_config
  localparam logic [3:0] REG_IRQ_IDX = 4'h1; // controller_irq_flags
  localparam logic [3:0] REG_DROP_IDX = 4'h2; // rx_dropped_frame_count
  localparam logic [3:0] REG_CON1_IDX = 4'h3; // controller_control_one
  localparam logic [3:0] REG_WMARK_IDX = 4'h4; // watermark_thresholds
  localparam logic [3:0] REG_STAT_IDX = 4'h5; // controller_status
  localparam logic [7:0] REG_FILTER_OFS = 8'h00;
  localparam logic [7:0] REG_IRQ_OFS = 8'h10;
  localparam logic [7:0] REG_DROP_OFS = 8'h20;
  localparam logic [7:0] REG_CON1_OFS = 8'h30;
  localparam logic [7:0] REG_WMARK_OFS = 8'h40;
  localparam logic [7:0] REG_STAT_OFS = 8'h50;

  // alias slots inside each register's 16-byte window
  localparam logic [1:0] ALIAS_BASE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // ==========================================================
  // rx_filter_config fields
  localparam int HASH_EN_BIT = 15;
  localparam int WAKE_EN_BIT = 14;
  localparam int CSUM_INV_BIT = 12;
  localparam int PM_SEL_LSB = 8;
  localparam logic [31:0] FILTER_WMASK = 32'h0000_dfff;
  localparam logic [31:0] FILTER_RESET = 32'h0000_0000;

  // pattern_match_select codes
  localparam logic [3:0] PM_OFF = 4'h0;
  localparam logic [3:0] PM_CSUM = 4'h1;
  localparam logic [3:0] PM_STATION_A = 4'h2;
  localparam logic [3:0] PM_STATION_B = 4'h3;
  localparam logic [3:0] PM_UNICAST_A = 4'h4;
  localparam logic [3:0] PM_UNICAST_B = 4'h5;
  localparam logic [3:0] PM_BCAST_A = 4'h6;
  localparam logic [3:0] PM_BCAST_B = 4'h7;
  localparam logic [3:0] PM_HASH = 4'h8;
  localparam logic [3:0] PM_WAKEUP = 4'h9;

  // ==========================================================
  // controller_irq_flags fields
  localparam int TX_BUSERR_BIT = 14;
  localparam int RX_BUSERR_BIT = 13;
  localparam int EMPTY_WM_BIT = 9;
  localparam int FULL_WM_BIT = 8;
  localparam int RX_OVF_BIT = 0;
  localparam logic [31:0] IRQ_WMASK = 32'h0000_6001;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

  // dropped counter, control, thresholds, status
  localparam logic [31:0] DROP_WMASK = 32'h0000_ffff;
  localparam logic [15:0] DROP_RESET = 16'h0000;
  localparam int RX_EN_BIT = 8;
  localparam int BUF_DEC_BIT = 0;
  localparam logic [31:0] CON1_WMASK = 32'h0000_0100;
  localparam logic [31:0] CON1_RESET = 32'h0000_0000;
  localparam int EMPTY_THR_LSB = 0;
  localparam int FULL_THR_LSB = 16;
  localparam logic [31:0] WMARK_WMASK = 32'h00ff_00ff;
  localparam logic [31:0] WMARK_RESET = 32'h0000_0000;
  localparam int BUF_CNT_LSB = 16;
  localparam logic [7:0] BUF_CNT_RESET = 8'h00;

  // ==========================================================
  // frame descriptor fields from the receive path
  localparam int FRAME_W = 7;
  localparam int FI_CSUM = 0;
  localparam int FI_STATION = 1;
  localparam int FI_UNICAST = 2;
  localparam int FI_BCAST = 3;
  localparam int FI_HASH = 4;
  localparam int FI_WAKEUP = 5;
  localparam int FI_OVERRUN = 6;
  localparam int FIFO_DEPTH = 16;

  // ahb transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// File: common/erxf_stream_if.sv
/*
  erxf_stream_if: valid/ready word stream between the filter core and
  its descriptor buffer. Assumes a single clock for both ends.
*/
`timescale 1ns/1ps
interface erxf_stream_if #(parameter int WIDTH = 7);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: core/erxf_fifo.sv
/*
  erxf_fifo: synchronous FIFO of DEPTH words of WIDTH bits.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module erxf_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  erxf_stream_if.snk in_s,
  erxf_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } erxf_fifo_s;

  erxf_fifo_s st_reg;
  erxf_fifo_s st_next;
  logic full;
  logic empty;

  // ==========================================================
  // flags and handshakes
  assign empty = (st_reg.wp == st_reg.rp);
  assign full = (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]) && (st_reg.wp[AW] != st_reg.rp[AW]);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = st_reg.mem[st_reg.rp[AW-1:0]];

  // pointer and storage update
  always_comb
  begin
    st_next = st_reg;
    if (in_s.valid && !full)
    begin
      st_next.mem[st_reg.wp[AW-1:0]] = in_s.data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (out_s.ready && !empty)
      st_next.rp = st_reg.rp + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule

// File: core/erxf_top.sv
/*
  erxf_top: receive filter configuration and pattern match, controller
  interrupt flags, descriptor watermarks and dropped-frame counter,
  behind an AHB-Lite slave. Assumes the receive path, the DMA engines
  and the descriptor logic run on hclk and give one-cycle event pulses.
*/
// The implementer's own choices: the AHB-Lite register port and the address map.
// Contract
// - hash filter applies only when enabled
// - wake-up filter applies only when enabled
// - inversion bit xors checksum match condition
// - mode zero makes pattern match fail
// - mode one needs checksum condition only
// - modes two/three also need station address
// - modes four/five also need unicast address
// - modes six/seven also need broadcast address
// - mode eight needs hash hit regardless
// - mode nine needs wake-up hit regardless
// - tx bus error sets sticky flag
// - rx bus error sets sticky flag
// - empty watermark sets low, clears on increment
// - full watermark sets high, clears on decrement
// - dropped accepted frame counts, sets overflow flag
// - counter clears on read touching bytes 0/1
`timescale 1ns/1ps
module erxf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire logic [erxf_pkg::FRAME_W-1:0] frame_info,
  output logic result_valid,
  input wire logic result_ready,
  output logic result_accept,
  output logic result_match,
  output logic result_dropped,
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  input wire logic buf_count_inc,
  output logic receive_enable
);

  typedef struct packed {
    logic [31:0] filter;
    logic [31:0] irq;
    logic [15:0] drop_cnt;
    logic [31:0] con1;
    logic [31:0] wmark;
    logic [7:0] buf_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic res_valid;
    logic res_accept;
    logic res_match;
    logic res_dropped;
  } erxf_state_s;

  erxf_state_s st_reg;
  erxf_state_s st_next;

  erxf_stream_if #(.WIDTH(erxf_pkg::FRAME_W)) fifo_in ();
  erxf_stream_if #(.WIDTH(erxf_pkg::FRAME_W)) fifo_out ();

  logic addr_phase;
  logic [7:0] req_addr;
  logic lanes_low;
  logic take_frame;
  logic [erxf_pkg::FRAME_W-1:0] fi;
  logic [3:0] pm_sel;
  logic csum_ok;
  logic pm_hit;
  logic hash_ok;
  logic wake_ok;
  logic accept;
  logic dropped;
  logic buf_dec;

  // ==========================================================
  // descriptor buffer between receive path and filter
  assign fifo_in.valid = frame_valid;
  assign fifo_in.data = frame_info;
  assign frame_ready = fifo_in.ready;
  assign take_frame = fifo_out.valid && (!st_reg.res_valid || result_ready);
  assign fifo_out.ready = !st_reg.res_valid || result_ready;
  assign fi = fifo_out.data;

  erxf_fifo #(
    .WIDTH(erxf_pkg::FRAME_W),
    .DEPTH(erxf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );

  // ==========================================================
  // pattern match evaluation of the frame at the buffer head
  assign pm_sel = st_reg.filter[erxf_pkg::PM_SEL_LSB +: 4];
  assign csum_ok = st_reg.filter[erxf_pkg::CSUM_INV_BIT] ^ fi[erxf_pkg::FI_CSUM];

  always_comb
  begin
    case (pm_sel)
      erxf_pkg::PM_OFF: pm_hit = 1'b0;
      erxf_pkg::PM_CSUM: pm_hit = csum_ok;
      erxf_pkg::PM_STATION_A,
      erxf_pkg::PM_STATION_B: pm_hit = csum_ok && fi[erxf_pkg::FI_STATION];
      erxf_pkg::PM_UNICAST_A,
      erxf_pkg::PM_UNICAST_B: pm_hit = csum_ok && fi[erxf_pkg::FI_UNICAST];
      erxf_pkg::PM_BCAST_A,
      erxf_pkg::PM_BCAST_B: pm_hit = csum_ok && fi[erxf_pkg::FI_BCAST];
      erxf_pkg::PM_HASH: pm_hit = csum_ok && fi[erxf_pkg::FI_HASH];
      erxf_pkg::PM_WAKEUP: pm_hit = csum_ok && fi[erxf_pkg::FI_WAKEUP];
      default: pm_hit = 1'b0;
    endcase
  end

  // enabled filters gate acceptance; disabled ones pass everything
  assign hash_ok = !st_reg.filter[erxf_pkg::HASH_EN_BIT] || fi[erxf_pkg::FI_HASH];
  assign wake_ok = !st_reg.filter[erxf_pkg::WAKE_EN_BIT] || fi[erxf_pkg::FI_WAKEUP];
  assign accept = hash_ok && wake_ok && ((pm_sel == erxf_pkg::PM_OFF) || pm_hit);
  assign dropped = take_frame && accept && fi[erxf_pkg::FI_OVERRUN];

  // ==========================================================
  // bus address phase and read byte lanes
  assign addr_phase = hsel && hready && (htrans == erxf_pkg::HTRANS_NONSEQ ||
                      htrans == erxf_pkg::HTRANS_SEQ);
  assign req_addr = haddr[7:0];
  assign lanes_low = (hsize >= 3'h2) || (hsize == 3'h1 && !haddr[1]) ||
                     (hsize == 3'h0 && !haddr[1]);
  assign buf_dec = st_reg.wr_pend && (st_reg.wr_addr[7:4] == erxf_pkg::REG_CON1_IDX) &&
                   (st_reg.wr_addr[3:2] != erxf_pkg::ALIAS_CLR) &&
                   hwdata[erxf_pkg::BUF_DEC_BIT];

  // apply a base, clear, set or invert write to the writable bits
  function automatic logic [31:0] alias_apply(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [1:0] slot,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = wd & wmask;
    case (slot)
      erxf_pkg::ALIAS_BASE: alias_apply = (old & ~wmask) | m;
      erxf_pkg::ALIAS_CLR: alias_apply = old & ~m;
      erxf_pkg::ALIAS_SET: alias_apply = old | m;
      erxf_pkg::ALIAS_INV: alias_apply = old ^ m;
      default: alias_apply = old;
    endcase
  endfunction

  // read mux over the register image
  function automatic logic [31:0] read_word(
    input erxf_state_s s,
    input logic [3:0] idx
  );
    case (idx)
      erxf_pkg::REG_FILTER_IDX: read_word = s.filter;
      erxf_pkg::REG_IRQ_IDX: read_word = s.irq;
      erxf_pkg::REG_DROP_IDX: read_word = {16'h0000, s.drop_cnt};
      erxf_pkg::REG_CON1_IDX: read_word = s.con1;
      erxf_pkg::REG_WMARK_IDX: read_word = s.wmark;
      erxf_pkg::REG_STAT_IDX: read_word = {8'h00, s.buf_cnt, 16'h0000};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================
  // next-state: software writes first, hardware events win after
  always_comb
  begin
    logic [31:0] drop_word;
    logic [1:0] slot;
    drop_word = 32'h0000_0000;
    slot = st_reg.wr_addr[3:2];
    st_next = st_reg;

    // data phase of a captured write (filter may change any time;
    // software is expected to hold receive disabled meanwhile)
    if (st_reg.wr_pend)
    begin
      case (st_reg.wr_addr[7:4])
        erxf_pkg::REG_FILTER_IDX:
          st_next.filter = alias_apply(st_reg.filter, hwdata, slot, erxf_pkg::FILTER_WMASK);
        erxf_pkg::REG_IRQ_IDX:
          st_next.irq = alias_apply(st_reg.irq, hwdata, slot, erxf_pkg::IRQ_WMASK);
        erxf_pkg::REG_DROP_IDX:
        begin
          drop_word = alias_apply({16'h0000, st_reg.drop_cnt}, hwdata, slot,
                                  erxf_pkg::DROP_WMASK);
          st_next.drop_cnt = drop_word[15:0];
        end
        erxf_pkg::REG_CON1_IDX:
          st_next.con1 = alias_apply(st_reg.con1, hwdata, slot, erxf_pkg::CON1_WMASK);
        erxf_pkg::REG_WMARK_IDX:
          st_next.wmark = alias_apply(st_reg.wmark, hwdata, slot, erxf_pkg::WMARK_WMASK);
        default: st_next.wmark = st_next.wmark;
      endcase
    end

    // descriptor buffer count follows increments and decrements
    if (buf_count_inc && !buf_dec)
      st_next.buf_cnt = st_reg.buf_cnt + 8'h01;
    else if (buf_dec && !buf_count_inc)
      st_next.buf_cnt = st_reg.buf_cnt - 8'h01;

    // watermark flags: event clears, condition on the updated count wins
    if (buf_count_inc)
      st_next.irq[erxf_pkg::EMPTY_WM_BIT] = 1'b0;
    if (st_next.buf_cnt <= st_reg.wmark[erxf_pkg::EMPTY_THR_LSB +: 8])
      st_next.irq[erxf_pkg::EMPTY_WM_BIT] = 1'b1;
    else if (!buf_count_inc)
      st_next.irq[erxf_pkg::EMPTY_WM_BIT] = st_reg.irq[erxf_pkg::EMPTY_WM_BIT];
    if (buf_dec)
      st_next.irq[erxf_pkg::FULL_WM_BIT] = 1'b0;
    else
      st_next.irq[erxf_pkg::FULL_WM_BIT] = st_reg.irq[erxf_pkg::FULL_WM_BIT];
    if (st_next.buf_cnt >= st_reg.wmark[erxf_pkg::FULL_THR_LSB +: 8])
      st_next.irq[erxf_pkg::FULL_WM_BIT] = 1'b1;

    // sticky bus error flags, set wins over a same-cycle clear
    if (tx_bus_error)
      st_next.irq[erxf_pkg::TX_BUSERR_BIT] = 1'b1;
    if (rx_bus_error)
      st_next.irq[erxf_pkg::RX_BUSERR_BIT] = 1'b1;

    // read capture sees any write landing in this same cycle
    if (addr_phase && !hwrite)
      st_next.rdata = read_word(st_next, req_addr[7:4]);
    else
      st_next.rdata = 32'h0000_0000;

    // clear-on-read of the dropped count, then count this drop
    if (addr_phase && !hwrite && req_addr[7:4] == erxf_pkg::REG_DROP_IDX && lanes_low)
      st_next.drop_cnt = erxf_pkg::DROP_RESET;
    if (dropped)
    begin
      st_next.drop_cnt = st_next.drop_cnt + 16'h0001;
      st_next.irq[erxf_pkg::RX_OVF_BIT] = 1'b1;
    end

    // capture a write address phase for the next cycle
    st_next.wr_pend = addr_phase && hwrite;
    st_next.wr_addr = req_addr;

    // result register toward the receive path
    if (take_frame)
    begin
      st_next.res_valid = 1'b1;
      st_next.res_accept = accept && !fi[erxf_pkg::FI_OVERRUN];
      st_next.res_match = pm_hit;
      st_next.res_dropped = dropped;
    end
    else if (result_ready)
      st_next.res_valid = 1'b0;
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
      st_reg.filter <= erxf_pkg::FILTER_RESET;
      st_reg.irq <= erxf_pkg::IRQ_RESET;
      st_reg.drop_cnt <= erxf_pkg::DROP_RESET;
      st_reg.con1 <= erxf_pkg::CON1_RESET;
      st_reg.wmark <= erxf_pkg::WMARK_RESET;
      st_reg.buf_cnt <= erxf_pkg::BUF_CNT_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1; // zero-wait slave
  assign hresp = 1'b0; // always okay
  assign hrdata = st_reg.rdata;
  assign result_valid = st_reg.res_valid;
  assign result_accept = st_reg.res_accept;
  assign result_match = st_reg.res_match;
  assign result_dropped = st_reg.res_dropped;
  assign receive_enable = st_reg.con1[erxf_pkg::RX_EN_BIT];

endmodule

// File: verification/erxf_top_properties.sv
/*
  erxf_top_properties: port-level checks of erxf_top.
  Assumes a zero-wait slave and the register map of erxf_pkg.
*/
`timescale 1ns/1ps
module erxf_top_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic result_accept,
  input wire logic result_match,
  input wire logic result_dropped,
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  input wire logic receive_enable
);
  // ==========================================================
  // shadows of data phases and registers
  logic rd_dp, wr_dp, rd_word, cz;
  logic [7:0] dp_a;
  logic [31:0] fm, iq, cs;
  function automatic logic [31:0] alias_f(input logic [31:0] o, input logic [31:0] w,
    input logic [1:0] s);
    case (s)
      erxf_pkg::ALIAS_CLR: return o & ~w;
      erxf_pkg::ALIAS_SET: return o | w;
      erxf_pkg::ALIAS_INV: return o ^ w;
      default: return w;
    endcase
  endfunction
  // track transfers and apply writes like the slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      rd_word <= 1'b0;
      cz <= 1'b0;
      dp_a <= 8'h00;
      fm <= 32'h0;
      iq <= 32'h0;
      cs <= 32'h0;
    end
    else
    begin
      rd_dp <= hsel && hready && htrans[1] && !hwrite;
      wr_dp <= hsel && hready && htrans[1] && hwrite;
      rd_word <= hsize == 3'h2;
      if (hsel && hready && htrans[1])
        dp_a <= haddr[7:0];
      if (wr_dp && dp_a[7:4] == 4'h0)
        fm <= alias_f(fm, hwdata, dp_a[3:2]) & erxf_pkg::FILTER_WMASK;
      if (wr_dp && dp_a[7:4] == 4'h3)
        cs <= alias_f(cs, hwdata, dp_a[3:2]) & erxf_pkg::CON1_WMASK;
      iq <= ((wr_dp && dp_a[7:4] == 4'h1) ? alias_f(iq, hwdata, dp_a[3:2]) & 32'h6000 : iq)
        | {17'h0, tx_bus_error, rx_bus_error, 13'h0};
      if ((result_dropped && result_valid) || (wr_dp && dp_a[7:4] == 4'h2))
        cz <= 1'b0;
      else if (rd_dp && dp_a[7:4] == 4'h2 && rd_word)
        cz <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // assertions
  a_idle_zero:
    assert property (!rd_dp |-> hrdata == 32'h0) else $error("read data not zero when idle");
  a_filter_read:
    assert property (rd_dp && dp_a == erxf_pkg::REG_FILTER_OFS |-> hrdata == fm)
    else $error("filter readback wrong");
  a_busflag_read:
    assert property (rd_dp && dp_a == erxf_pkg::REG_IRQ_OFS |-> hrdata[14:13] == iq[14:13])
    else $error("bus error flag readback wrong");
  a_irq_unused:
    assert property (rd_dp && dp_a == erxf_pkg::REG_IRQ_OFS |-> (hrdata & 32'hffff_9cfe) == 0)
    else $error("unused flag bits read nonzero");
  a_unmapped_zero:
    assert property (rd_dp && dp_a[7:4] > 4'h5 |-> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  a_receive_enable_follow:
    assert property (receive_enable == cs[8]) else $error("receive enable wrong");
  a_count_cleared:
    assert property (rd_dp && dp_a == erxf_pkg::REG_DROP_OFS && cz |-> hrdata == 32'h0)
    else $error("counter not cleared by read");
  a_mode_off:
    assert property (result_valid && fm[11:8] == 4'h0 |-> !result_match)
    else $error("match with pattern match off");
  a_result_hold:
    assert property (result_valid && !result_ready |=> result_valid
      && $stable({result_accept, result_match, result_dropped}))
    else $error("result changed while stalled");
  a_drop_excl:
    assert property (result_valid |-> !(result_accept && result_dropped))
    else $error("frame both accepted and dropped");
  c_drop: cover property (result_valid && result_dropped);
  c_stall: cover property (result_valid && !result_ready ##1 result_valid);
  c_clear: cover property (rd_dp && dp_a == erxf_pkg::REG_DROP_OFS && cz);
endmodule

// File: verification/erxf_rx_model.sv
/*
  erxf_rx_model: receive path offering frame descriptors and taking results.
  Assumes its tasks are entered just after a rising hclk edge.
*/
`timescale 1ns/1ps
module erxf_rx_model (
  input wire logic hclk,
  input wire logic frame_ready,
  input wire logic result_valid,
  input wire logic result_accept,
  input wire logic result_match,
  input wire logic result_dropped,
  output logic frame_valid,
  output logic [erxf_pkg::FRAME_W-1:0] frame_info,
  output logic result_ready
);
  // idle at start
  initial
  begin
    frame_valid = 1'b0;
    frame_info = '0;
    result_ready = 1'b0;
  end
  // offer one descriptor, hold until taken
  task automatic send(input logic [6:0] f, input logic last);
    int n;
    frame_valid <= 1'b1;
    frame_info <= f;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (frame_ready !== 1'b1 && n < 1000);
    if (last)
    begin
      frame_valid <= 1'b0;
      frame_info <= ~f; // released lines show junk
    end
  endtask
  // accept one result
  task automatic take(output logic [2:0] r, input logic last);
    int n;
    result_ready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (result_valid !== 1'b1 && n < 1000);
    r = {result_accept, result_match, result_dropped};
    if (last)
      result_ready <= 1'b0;
  endtask
endmodule

// File: verification/eth_rx_filter_irq_stats_bench.sv
/*
  eth_rx_filter_irq_stats_bench: self-checking bench of erxf_top.
  Assumes erxf_rx_model on the frame side and AHB-Lite single transfers.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module eth_rx_filter_irq_stats_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, evs = 3'h0, r;
  logic hreadyout, hresp, frame_valid, frame_ready, result_valid, result_ready;
  logic result_accept, result_match, result_dropped, receive_enable;
  logic [6:0] frame_info;
  int fails = 0, n_compared = 0;
  // ==========================================================
  // clock, design and frame side
  always #2.5 hclk = ~hclk;
  erxf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_info(frame_info), .result_valid(result_valid),
    .result_ready(result_ready), .result_accept(result_accept), .result_match(result_match),
    .result_dropped(result_dropped), .tx_bus_error(evs[0]), .rx_bus_error(evs[1]),
    .buf_count_inc(evs[2]), .receive_enable(receive_enable));
  erxf_rx_model rx (.hclk(hclk), .frame_ready(frame_ready), .result_valid(result_valid),
    .result_accept(result_accept), .result_match(result_match),
    .result_dropped(result_dropped), .frame_valid(frame_valid), .frame_info(frame_info),
    .result_ready(result_ready));
  // ==========================================================
  // bus and event tasks
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= erxf_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, 3'h2, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 3'h2, 32'h0, q);
    `CHK({hresp, q}, {1'b0, e})
  endtask
  task automatic ev(input int k);
    evs <= 3'h1 << k;
    @(posedge hclk);
    evs <= 3'h0;
    @(posedge hclk);
  endtask
  function automatic logic exp_m(input int md, input logic inv, input logic [6:0] f);
    logic c;
    c = f[0] ^ inv;
    case (md)
      1: return c;
      2, 3: return c & f[1];
      4, 5: return c & f[2];
      6, 7: return c & f[3];
      8: return c & f[4];
      9: return c & f[5];
      default: return 1'b0;
    endcase
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rdc(8'h10, 32'h0000_0300);
    rdc(8'h60, 32'h0);
    wr(8'h00, 32'hffff_ffff);
    rdc(8'h00, 32'h0000_dfff);
    wr(8'h04, 32'h0000_0f00);
    rdc(8'h00, 32'h0000_d0ff);
    wr(8'h08, 32'h0000_0100);
    rdc(8'h00, 32'h0000_d1ff);
    wr(8'h0c, 32'h0000_8001);
    rdc(8'h00, 32'h0000_51fe);
    wr(8'h38, 32'h0000_0100);
    rdc(8'h30, 32'h0000_0100);
    wr(8'h34, 32'h0000_0100);
  endtask
  task automatic t_errors;
    ev(0);
    ev(1);
    rdc(8'h10, 32'h0000_6300);
    wr(8'h1c, 32'h0);
    rdc(8'h10, 32'h0000_6300);
    wr(8'h14, 32'h0000_4000);
    rdc(8'h10, 32'h0000_2300);
    wr(8'h18, 32'h0000_4000);
    rdc(8'h10, 32'h0000_6300);
    wr(8'h14, 32'h0000_6300);
    rdc(8'h10, 32'h0000_0300);
  endtask
  task automatic t_modes;
    logic [31:0] q;
    int tally;
    tally = 0;
    for (int md = 0; md < 10; md++)
      for (int cf = 0; cf < 8; cf++)
      begin
        wr(8'h00, {16'h0, cf[2], cf[1], 1'b0, cf[0], md[3:0], 8'h0});
        fork
          for (int f = 0; f < 128; f++)
            rx.send(f[6:0], f == 127);
          for (int f = 0; f < 128; f++)
          begin
            logic m, acc;
            rx.take(r, f == 127);
            m = exp_m(md, cf[0], f[6:0]);
            acc = (!cf[2] | f[4]) & (!cf[1] | f[5]) & (md == 0 | m);
            `CHK(r, {acc & !f[6], m, acc & f[6]})
            tally += int'(acc & f[6]);
          end
        join
      end
    bus(1'b0, 8'h22, 3'h0, 32'h0, q);
    rdc(8'h20, {16'h0, tally[15:0]});
    rdc(8'h20, 32'h0);
    rdc(8'h10, 32'h0000_0301);
    wr(8'h14, 32'h0000_0001);
    rdc(8'h10, 32'h0000_0300);
  endtask
  task automatic t_fifo;
    wr(8'h00, 32'h0000_0100);
    for (int i = 0; i < 17; i++)
      rx.send({6'h0, i[0]}, i == 16);
    repeat (2) @(posedge hclk);
    `CHK(frame_ready, 1'b0)
    for (int i = 0; i < 17; i++)
    begin
      rx.take(r, i == 16);
      `CHK(r, {i[0], i[0], 1'b0})
    end
    `CHK(frame_ready, 1'b1)
  endtask
  task automatic t_wmark;
    logic [1:0] fl [6] = '{2'b01, 2'b01, 2'b00, 2'b10, 2'b00, 2'b01};
    int k;
    k = 0;
    wr(8'h40, 32'h0002_0000);
    wr(8'h14, 32'h0000_0300);
    rdc(8'h10, 32'h0000_0300);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 2 || i == 3)
        wr(8'h38, 32'h0000_0001);
      else
        ev(2);
      k += (i == 2 || i == 3) ? -1 : 1;
      repeat (2) @(posedge hclk);
      rdc(8'h10, {22'h0, fl[i], 8'h0});
      rdc(8'h50, {8'h0, k[7:0], 16'h0});
    end
    wr(8'h18, 32'h0000_0200);
    rdc(8'h10, 32'h0000_0100);
  endtask
  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_errors();
    t_modes();
    t_fifo();
    t_wmark();
    conclude();
  end
endmodule
bind erxf_top erxf_top_properties chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .result_valid(result_valid),
  .result_ready(result_ready), .result_accept(result_accept), .result_match(result_match),
  .result_dropped(result_dropped), .tx_bus_error(tx_bus_error),
  .rx_bus_error(rx_bus_error), .receive_enable(receive_enable));
